// ===== shared/i2c_port_pkg.sv
// types shared by the two-wire slave register port
package i2c_port_pkg;
	typedef logic [8:0][7:0] cmd_bank_t;
	typedef struct packed {
		logic sclRise;
		logic sclFall;
		logic start;
		logic stop;
		logic sda;
	} bus_evt_t;
	typedef enum logic [9:0] {
		ST_IDLE     = 10'h001,
		ST_ADDR     = 10'h002,
		ST_ADDR_ACK = 10'h004,
		ST_SUB      = 10'h008,
		ST_SUB_ACK  = 10'h010,
		ST_DATA     = 10'h020,
		ST_DATA_ACK = 10'h040,
		ST_READ     = 10'h080,
		ST_READ_ACK = 10'h100,
		ST_IGNORE   = 10'h200
	} port_state_t;
endpackage

// ===== shared/i2c_port_regs.svh
// constants for the two-wire slave register port
`ifndef I2C_PORT_REGS_SVH
`define I2C_PORT_REGS_SVH
`define CLK_MHZ      100
`define SCL_MAX_KHZ  400
`define GLITCH_NS    50
`define GLITCH_CYC   ((`GLITCH_NS * `CLK_MHZ + 999) / 1000)
`define ADDR_PREFIX  3'h6
`define GLOBAL_ADDR  7'h0C
`define BCAST_CMD    8'h18
`define NUM_CMD      9
`define PART_FIRST   8'h0A
`define PART_LAST    8'h0C
// part number bytes, values are arbitrary
`define PART_NUM0    8'h5A
`define PART_NUM1    8'hA5
`define PART_NUM2    8'h3C
`define DEF_CONFIG   8'h0C
`define DEF_PWM      8'h00
`define DEF_ADIM     8'hFF
`define DEF_STATEN   8'hFF
`define DEF_REG9     8'h00
`define STRAP_GND    2'h0
`define STRAP_FLOAT  2'h1
`define STRAP_VCC    2'h2
`endif

// ===== verification/i2c_master_model.sv
// bus master model that clocks the two-wire port
module i2c_master_model (
	input  wire logic mclk,
	input  wire logic sdaLine,
	output logic      scl,
	output logic      sdaDrv
);
	timeunit 1ns;
	timeprecision 1ps;
	// both lines idle high
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end
	// set both lines after an edge, then hold for n cycles
	task automatic put(logic c, logic d, int n);
		@(posedge mclk);
		scl <= c;
		sdaDrv <= d;
		repeat (n - 1) @(posedge mclk);
	endtask
	// data moves only while the clock is low; 252 cycles a bit
	task automatic bitx(logic b, output logic r);
		put(1'b0, sdaDrv, 20);
		put(1'b0, b, 106);
		put(1'b1, b, 126);
		r = sdaLine;
	endtask
	// data falls while the clock is high
	task automatic start();
		put(1'b0, sdaDrv, 20);
		put(1'b0, 1'b1, 106);
		put(1'b1, 1'b1, 126);
		put(1'b1, 1'b0, 126);
	endtask
	// data pulse with the clock high, shorter than the input filter
	task automatic glitch();
		put(1'b1, 1'b0, 3);
		put(1'b1, 1'b1, 10);
	endtask
	// data rises while the clock is high
	task automatic stop();
		put(1'b0, sdaDrv, 20);
		put(1'b0, 1'b0, 106);
		put(1'b1, 1'b0, 126);
		put(1'b1, 1'b1, 126);
	endtask
	// eight bits msb first, then the acknowledge clock
	task automatic xfer(logic [7:0] d, logic ak, output logic [7:0] r,
		output logic a);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r[i]);
		bitx(ak, a);
	endtask
endmodule

// ===== verification/i2c_port_monitor.sv
// pin-level checks for the two-wire slave register port
`include "i2c_port_regs.svh"
module i2c_port_monitor
	import i2c_port_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	input  wire logic       sdaOe,
	input  wire logic [1:0] strapLowIn,
	input  wire logic [1:0] strapHighIn,
	input  wire logic       supplyOkIn,
	input  wire cmd_bank_t  cmdRegs,
	input  wire logic       i2cMode,
	input  wire logic       dimSyncPulse,
	input  wire logic       commitPulse
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] upCnt_ff;
	logic       bothGnd;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	// both straps tied to ground
	assign bothGnd = strapLowIn == `STRAP_GND && strapHighIn == `STRAP_GND;
	// cycles since reset or supply recovery, saturating
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			upCnt_ff <= 4'h0;
		else if (!supplyOkIn)
			upCnt_ff <= 4'h0;
		else if (upCnt_ff != 4'hF)
			upCnt_ff <= upCnt_ff + 4'h1;
	end
	chk_oe_clock_low: assert property (
		$changed(sdaOe) |-> !sclIn)
		else $error("data drive moved with clock high");
	chk_ack_after_fall: assert property (
		$rose(sdaOe) |-> !$past(sclIn, 4) && $past(sclIn, 14))
		else $error("data drive not tied to clock fall");
	chk_ack_hold: assert property (
		$rose(sclIn) && sdaOe |-> sdaOe [*8])
		else $error("acknowledge dropped in clock high");
	chk_commit_stop: assert property (
		commitPulse |-> sclIn && sdaIn && $past(sclIn, 14)
			&& !$past(sdaIn, 14))
		else $error("commit without stop");
	chk_regs_commit: assert property (
		$changed(cmdRegs) |-> commitPulse || upCnt_ff < 4'h4)
		else $error("command latches moved without commit");
	chk_sync_clean: assert property (
		dimSyncPulse |-> $stable(cmdRegs) ##1 !dimSyncPulse)
		else $error("sync pulse wrong");
	chk_mode_off: assert property (
		bothGnd |-> !i2cMode)
		else $error("serial mode with grounded straps");
	chk_mode_on: assert property (
		upCnt_ff == 4'hF && !bothGnd |-> i2cMode)
		else $error("serial mode missing");
endmodule

// ===== verification/tb.sv
// self-checking bench for the two-wire slave register port
`include "i2c_port_regs.svh"
module tb
	import i2c_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam cmd_bank_t defBank = {`DEF_REG9, `DEF_STATEN, `DEF_ADIM,
		`DEF_ADIM, {4{`DEF_PWM}}, `DEF_CONFIG};
	localparam logic [6:0] myAddr = {`ADDR_PREFIX, 4'hD};
	localparam logic [2:0][7:0] partTbl = {`PART_NUM2, `PART_NUM1, `PART_NUM0};
	localparam logic [8:0][3:0] nibTbl = {4'hF, 4'hD, 4'hC, 4'h7, 4'h5,
		4'h4, 4'h3, 4'h1, 4'h0};
	logic       mclk;
	logic       resetn = 1'b0;
	logic       supplyOkIn = 1'b1;
	logic [1:0] strapLowIn = `STRAP_FLOAT;
	logic [1:0] strapHighIn = `STRAP_VCC;
	logic       scl, sdaDrv, sdaOut, sdaOe, i2cMode, dimSyncPulse, commitPulse;
	wire logic  sdaLine;
	cmd_bank_t  cmdRegs, expBank;
	int         failures = 0, n_checks = 0, syncCnt = 0, cycles = 0;
	int         commitCnt = 0;
	// pulled-up wire, low when either side pulls
	assign sdaLine = (sdaOe ? sdaOut : 1'b1) & sdaDrv;
	i2c_slave_register_port uut (.mclk(mclk), .resetn(resetn), .sclIn(scl),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.strapLowIn(strapLowIn), .strapHighIn(strapHighIn),
		.supplyOkIn(supplyOkIn), .cmdRegs(cmdRegs), .i2cMode(i2cMode),
		.dimSyncPulse(dimSyncPulse), .commitPulse(commitPulse));
	i2c_master_model mst (.mclk(mclk), .sdaLine(sdaLine), .scl(scl),
		.sdaDrv(sdaDrv));
	// clock, pulse counts and hang limit
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (dimSyncPulse === 1'b1)
			syncCnt++;
		if (commitPulse === 1'b1)
			commitCnt++;
		if (cycles == 100000) begin
			failures++;
			$display("mismatch runTime exp 100000 got over");
			final_report();
		end
	end
	task automatic chk(string nm, logic [71:0] e, logic [71:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic doReset(logic [1:0] hi, logic [1:0] lo);
		@(posedge mclk);
		resetn <= 1'b0;
		strapHighIn <= hi;
		strapLowIn <= lo;
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		repeat (12) @(posedge mclk);
	endtask
	task automatic sendB(logic [7:0] d, logic ak, string nm);
		logic [7:0] r;
		logic       a;
		mst.xfer(d, 1'b1, r, a);
		chk(nm, 72'(ak), 72'(a));
	endtask
	task automatic ptr(logic [6:0] a7, logic [7:0] sub);
		mst.start();
		sendB({a7, 1'b0}, 1'b0, "wrAddr");
		sendB(sub, 1'b0, "subAddr");
	endtask
	task automatic readB(logic [6:0] a7, logic [7:0] e, string nm);
		logic [7:0] r;
		logic       a;
		mst.start();
		sendB({a7, 1'b1}, 1'b0, "rdAddr");
		mst.xfer(8'hFF, 1'b1, r, a);
		chk(nm, 72'(e), 72'(r));
	endtask
	task automatic testWrite();
		logic [7:0] r;
		logic       a;
		chk("bootRegs", defBank, cmdRegs);
		ptr(myAddr, 8'h02);
		sendB(8'hC1, 1'b0, "dataAck");
		mst.start();
		sendB({7'h6C, 1'b0}, 1'b1, "otherNack");
		readB(myAddr, 8'hC1, "heldRead");
		mst.glitch();
		chk("uncommitted", defBank, cmdRegs);
		mst.stop();
		expBank = defBank;
		expBank[1] = 8'hC1;
		chk("committed", expBank, cmdRegs);
		chk("commitPulse", 72'd1, 72'(commitCnt));
		mst.start();
		sendB({myAddr, 1'b1}, 1'b0, "pollAddr");
		mst.xfer(8'hFF, 1'b0, r, a);
		chk("pollRead", 72'hC1, 72'(r));
		mst.xfer(8'hFF, 1'b1, r, a);
		chk("ackedRead", 72'hC1, 72'(r));
		$display("test write done");
	endtask
	task automatic testGlobal();
		logic [7:0] r;
		logic       a;
		int         n;
		ptr(`GLOBAL_ADDR, 8'h09);
		sendB(8'h5E, 1'b0, "globalData");
		mst.stop();
		expBank[8] = 8'h5E;
		chk("globalCommit", expBank, cmdRegs);
		ptr(myAddr, 8'h00);
		sendB(8'h77, 1'b0, "unmappedAck");
		mst.stop();
		chk("unmapped", expBank, cmdRegs);
		chk("commitCount", 72'd2, 72'(commitCnt));
		n = syncCnt;
		mst.start();
		sendB({`GLOBAL_ADDR, 1'b0}, 1'b0, "bcastAddr");
		mst.xfer(`BCAST_CMD, 1'b1, r, a);
		chk("bcastAck", 72'd0, 72'(a));
		mst.stop();
		chk("syncPulse", 72'(n + 1), 72'(syncCnt));
		chk("bcastRegs", expBank, cmdRegs);
		for (int i = 0; i < 3; i++) begin
			ptr(myAddr, 8'(`PART_FIRST + i));
			readB((i == 1) ? `GLOBAL_ADDR : myAddr, partTbl[i],
				"partNum");
		end
		mst.stop();
		$display("test global done");
	endtask
	task automatic testSupply();
		@(posedge mclk);
		supplyOkIn <= 1'b0;
		repeat (10) @(posedge mclk);
		chk("supplyRegs", defBank, cmdRegs);
		supplyOkIn <= 1'b1;
		repeat (12) @(posedge mclk);
		$display("test supply done");
	endtask
	task automatic testStraps();
		for (int i = 0; i < 9; i++) begin
			doReset(2'(i / 3), 2'(i % 3));
			chk("mode", 72'(i != 0), 72'(i2cMode));
			mst.start();
			sendB({`ADDR_PREFIX, nibTbl[i], 1'b0}, 1'b0, "strap");
		end
		mst.stop();
		$display("test straps done");
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// main sequence
	initial begin
		doReset(`STRAP_VCC, `STRAP_FLOAT);
		testWrite();
		testGlobal();
		testSupply();
		testStraps();
		final_report();
	end
endmodule
bind i2c_slave_register_port i2c_port_monitor mon (.mclk(mclk),
	.resetn(resetn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe),
	.strapLowIn(strapLowIn), .strapHighIn(strapHighIn),
	.supplyOkIn(supplyOkIn), .cmdRegs(cmdRegs), .i2cMode(i2cMode),
	.dimSyncPulse(dimSyncPulse), .commitPulse(commitPulse));

// ===== verilog/i2c_slave_register_port.sv
// two-wire slave port with holding and command latches
`include "i2c_port_regs.svh"

module i2c_slave_register_port
	import i2c_port_pkg::*;
(
	input  wire logic      mclk,
	input  wire logic      resetn,
	input  wire logic      sclIn,
	input  wire logic      sdaIn,
	output logic           sdaOut,
	output logic           sdaOe,
	input  wire logic [1:0] strapLowIn,
	input  wire logic [1:0] strapHighIn,
	input  wire logic      supplyOkIn,
	output cmd_bank_t      cmdRegs,
	output logic           i2cMode,
	output logic           dimSyncPulse,
	output logic           commitPulse
);

	// reset value of each command register
	function automatic logic [7:0] defaultOf(input int idx);
		case (idx)
			0:       defaultOf = `DEF_CONFIG;
			1, 2, 3, 4: defaultOf = `DEF_PWM;
			5, 6:    defaultOf = `DEF_ADIM;
			7:       defaultOf = `DEF_STATEN;
			default: defaultOf = `DEF_REG9;
		endcase
	endfunction

	// sub-address selects an implemented command register
	function automatic logic isCmd(input logic [7:0] p);
		isCmd = (p >= 8'h01) && (p <= 8'(`NUM_CMD));
	endfunction

	// three-level strap pair to low address nibble
	function automatic logic [3:0] strapDecode(input logic [1:0] hi,
		input logic [1:0] lo);
		logic [1:0] h;
		logic [1:0] l;
		h = (hi == 2'h3) ? `STRAP_FLOAT : hi;
		l = (lo == 2'h3) ? `STRAP_FLOAT : lo;
		case ({h, l})
			{`STRAP_GND, `STRAP_FLOAT}:   strapDecode = 4'h1;
			{`STRAP_GND, `STRAP_VCC}:     strapDecode = 4'h3;
			{`STRAP_FLOAT, `STRAP_GND}:   strapDecode = 4'h4;
			{`STRAP_FLOAT, `STRAP_FLOAT}: strapDecode = 4'h5;
			{`STRAP_FLOAT, `STRAP_VCC}:   strapDecode = 4'h7;
			{`STRAP_VCC, `STRAP_GND}:     strapDecode = 4'hC;
			{`STRAP_VCC, `STRAP_FLOAT}:   strapDecode = 4'hD;
			{`STRAP_VCC, `STRAP_VCC}:     strapDecode = 4'hF;
			default:                      strapDecode = 4'h0;
		endcase
	endfunction

	logic [1:0]  lineMeta_ff;
	logic [1:0]  lineSync_ff;
	logic [1:0]  lineFilt;
	logic [1:0]  linePrev_ff;
	logic        supMeta_ff;
	logic        supSync_ff;
	logic [3:0]  strapMeta_ff;
	logic [3:0]  strapSync_ff;
	logic [3:0]  strapAddr_ff;
	logic        strapDone_ff;
	logic        i2cMode_ff;
	logic        ready;
	bus_evt_t    evt;
	port_state_t state_ff;
	logic [3:0]  bitCnt_ff;
	logic [7:0]  shift_ff;
	logic [7:0]  txByte_ff;
	logic [7:0]  ptr_ff;
	logic        isGlobal_ff;
	logic        bcast_ff;
	logic        mAck_ff;
	logic        sdaOe_ff;
	logic        dimSync_ff;
	logic        pending_ff;
	logic        commit_ff;
	logic        byteDone;
	logic        holdWr;
	logic        addrHit;
	logic [7:0]  rdByte;
	cmd_bank_t   hold_ff;
	cmd_bank_t   active_ff;

	// two-stage synchronisers for bus lines, straps and supply monitor
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lineMeta_ff  <= 2'h3;
			lineSync_ff  <= 2'h3;
			supMeta_ff   <= 1'b0;
			supSync_ff   <= 1'b0;
			strapMeta_ff <= 4'h0;
			strapSync_ff <= 4'h0;
		end else begin
			lineMeta_ff  <= {sdaIn, sclIn};
			lineSync_ff  <= lineMeta_ff;
			supMeta_ff   <= supplyOkIn;
			supSync_ff   <= supMeta_ff;
			strapMeta_ff <= {strapHighIn, strapLowIn};
			strapSync_ff <= strapMeta_ff;
		end
	end

	// line takes a new level only after it stays there GLITCH_CYC cycles
	// sized so 400 kHz clock high and low times pass untouched
	generate
		for (genvar g = 0; g < 2; g++) begin : gFilt
			logic [2:0] cnt_ff;
			logic       filt_ff;
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					cnt_ff  <= 3'h0;
					filt_ff <= 1'b1;
				end else if (lineSync_ff[g] == filt_ff) begin
					cnt_ff <= 3'h0;
				end else if (cnt_ff == 3'(`GLITCH_CYC - 1)) begin
					cnt_ff  <= 3'h0;
					filt_ff <= lineSync_ff[g];
				end else begin
					cnt_ff <= cnt_ff + 3'h1;
				end
			end
			assign lineFilt[g] = filt_ff;
		end
	endgenerate

	// previous filtered levels for edge detection
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			linePrev_ff <= 2'h3;
		end else begin
			linePrev_ff <= lineFilt;
		end
	end

	// bus events from the filtered lines
	always_comb begin
		evt.sclRise = lineFilt[0] & ~linePrev_ff[0];
		evt.sclFall = ~lineFilt[0] & linePrev_ff[0];
		evt.start   = lineFilt[0] & linePrev_ff[0] & linePrev_ff[1] &
			~lineFilt[1];
		evt.stop    = lineFilt[0] & linePrev_ff[0] & ~linePrev_ff[1] &
			lineFilt[1];
		evt.sda     = lineFilt[1];
	end

	// straps caught once after reset or supply recovery
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			strapAddr_ff <= 4'h0;
			strapDone_ff <= 1'b0;
			i2cMode_ff   <= 1'b0;
		end else if (!supSync_ff) begin
			strapDone_ff <= 1'b0;
			i2cMode_ff   <= 1'b0;
		end else if (!strapDone_ff) begin
			strapDone_ff <= 1'b1;
			strapAddr_ff <= strapDecode(strapSync_ff[3:2],
				strapSync_ff[1:0]);
			i2cMode_ff   <= (strapSync_ff != 4'h0);
		end
	end

	assign ready    = supSync_ff & strapDone_ff;
	assign byteDone = evt.sclFall && (bitCnt_ff == 4'h8);
	assign addrHit  = (shift_ff[7:1] == {`ADDR_PREFIX, strapAddr_ff}) ||
		(shift_ff[7:1] == `GLOBAL_ADDR);
	assign holdWr   = (state_ff == ST_DATA) && byteDone &&
		isCmd(ptr_ff);

	// read mux returns holding latches, then part number bytes
	always_comb begin
		rdByte = 8'h00;
		for (int i = 0; i < `NUM_CMD; i++) begin
			if (ptr_ff == 8'(i + 1)) begin
				rdByte = hold_ff[i];
			end
		end
		case (ptr_ff)
			`PART_FIRST:     rdByte = `PART_NUM0;
			8'(`PART_FIRST + 1): rdByte = `PART_NUM1;
			`PART_LAST:      rdByte = `PART_NUM2;
			default:         ;
		endcase
	end

	// byte engine: receive, acknowledge and transmit
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_ff    <= ST_IDLE;
			bitCnt_ff   <= 4'h0;
			shift_ff    <= 8'h00;
			txByte_ff   <= 8'h00;
			ptr_ff      <= 8'h00;
			isGlobal_ff <= 1'b0;
			bcast_ff    <= 1'b0;
			mAck_ff     <= 1'b0;
			sdaOe_ff    <= 1'b0;
		end else if (!ready) begin
			state_ff <= ST_IDLE;
			ptr_ff   <= 8'h00;
			sdaOe_ff <= 1'b0;
		end else if (evt.stop) begin
			state_ff <= ST_IDLE;
			sdaOe_ff <= 1'b0;
		end else if (evt.start) begin
			state_ff  <= ST_ADDR;
			bitCnt_ff <= 4'h0;
			sdaOe_ff  <= 1'b0;
		end else begin
			case (state_ff)
				ST_ADDR, ST_SUB, ST_DATA: begin
					if (evt.sclRise && bitCnt_ff < 4'h8) begin
						shift_ff  <= {shift_ff[6:0], evt.sda};
						bitCnt_ff <= bitCnt_ff + 4'h1;
					end
					if (byteDone) begin
						if (state_ff == ST_ADDR && !addrHit) begin
							state_ff <= ST_IGNORE;
						end else if (state_ff == ST_ADDR) begin
							sdaOe_ff    <= 1'b1;
							isGlobal_ff <= (shift_ff[7:1] == `GLOBAL_ADDR);
							state_ff    <= ST_ADDR_ACK;
						end else if (state_ff == ST_SUB) begin
							sdaOe_ff <= 1'b1;
							state_ff <= ST_SUB_ACK;
							bcast_ff <= isGlobal_ff && (shift_ff == `BCAST_CMD);
							if (!(isGlobal_ff && shift_ff == `BCAST_CMD)) begin
								ptr_ff <= shift_ff;
							end
						end else begin
							sdaOe_ff <= 1'b1;
							state_ff <= ST_DATA_ACK;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (evt.sclFall) begin
						bitCnt_ff <= 4'h0;
						if (shift_ff[0]) begin
							txByte_ff <= {rdByte[6:0], 1'b0};
							sdaOe_ff  <= ~rdByte[7];
							bitCnt_ff <= 4'h1;
							state_ff  <= ST_READ;
						end else begin
							sdaOe_ff <= 1'b0;
							state_ff <= ST_SUB;
						end
					end
				end
				ST_SUB_ACK: begin
					if (evt.sclFall) begin
						sdaOe_ff  <= 1'b0;
						bitCnt_ff <= 4'h0;
						state_ff  <= bcast_ff ? ST_IGNORE : ST_DATA;
					end
				end
				ST_DATA_ACK: begin
					if (evt.sclFall) begin
						sdaOe_ff <= 1'b0;
						state_ff <= ST_IGNORE;
					end
				end
				ST_READ: begin
					if (evt.sclFall && bitCnt_ff == 4'h8) begin
						sdaOe_ff <= 1'b0;
						state_ff <= ST_READ_ACK;
					end else if (evt.sclFall) begin
						sdaOe_ff  <= ~txByte_ff[7];
						txByte_ff <= {txByte_ff[6:0], 1'b0};
						bitCnt_ff <= bitCnt_ff + 4'h1;
					end
				end
				ST_READ_ACK: begin
					if (evt.sclRise) begin
						mAck_ff <= ~evt.sda;
					end
					if (evt.sclFall && mAck_ff) begin
						txByte_ff <= {rdByte[6:0], 1'b0};
						sdaOe_ff  <= ~rdByte[7];
						bitCnt_ff <= 4'h1;
						state_ff  <= ST_READ;
					end else if (evt.sclFall) begin
						state_ff <= ST_IGNORE;
					end
				end
				ST_IDLE, ST_IGNORE: ;
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// broadcast command pulses the dimming counter sync, no register write
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			dimSync_ff <= 1'b0;
		end else begin
			dimSync_ff <= ready && (state_ff == ST_SUB) && byteDone &&
				isGlobal_ff && (shift_ff == `BCAST_CMD);
		end
	end

	// pending data commits at STOP; a new write wins over the clear
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pending_ff <= 1'b0;
			commit_ff  <= 1'b0;
		end else if (!ready) begin
			pending_ff <= 1'b0;
			commit_ff  <= 1'b0;
		end else begin
			pending_ff <= holdWr | (pending_ff & ~evt.stop);
			commit_ff  <= evt.stop & pending_ff;
		end
	end

	// holding latches load on acknowledge of the data byte
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < `NUM_CMD; i++) begin
				hold_ff[i] <= defaultOf(i);
			end
		end else begin
			for (int i = 0; i < `NUM_CMD; i++) begin
				if (!supSync_ff) begin
					hold_ff[i] <= defaultOf(i);
				end else if (holdWr && ptr_ff == 8'(i + 1)) begin
					hold_ff[i] <= shift_ff;
				end
			end
		end
	end

	// command latches copy the holding latches at STOP
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < `NUM_CMD; i++) begin
				active_ff[i] <= defaultOf(i);
			end
		end else begin
			for (int i = 0; i < `NUM_CMD; i++) begin
				if (!supSync_ff) begin
					active_ff[i] <= defaultOf(i);
				end else if (ready && evt.stop && pending_ff) begin
					active_ff[i] <= hold_ff[i];
				end
			end
		end
	end

	// open-drain data: only ever pulls low
	assign sdaOut       = 1'b0;
	assign sdaOe        = sdaOe_ff;
	assign cmdRegs      = active_ff;
	assign i2cMode      = i2cMode_ff;
	assign dimSyncPulse = dimSync_ff;
	assign commitPulse  = commit_ff;

endmodule
